// ===== hdl/cisbt_cfg.svh
// offsets, field positions, reset values and cycle figures of the stack/block transfer unit
`ifndef CISBT_CFG_SVH
`define CISBT_CFG_SVH

`define CISBT_OFF_INSTR      8'h00
`define CISBT_OFF_STATUS     8'h04
`define CISBT_OFF_PC         8'h08
`define CISBT_OFF_PSW        8'h0C
`define CISBT_OFF_SP         8'h10
`define CISBT_OFF_LR         8'h14
`define CISBT_OFF_CYCLES     8'h18
`define CISBT_LOW_TOP        3'h1

`define CISBT_RST_WORD       32'h0000_0000
`define CISBT_PC_AHEAD       32'h0000_0004
`define CISBT_PC_BIT1        32'h0000_0002
`define CISBT_PC_STEP        32'h0000_0002
`define CISBT_PC_BIT0        32'h0000_0001

`define CISBT_OPC_HI         15
`define CISBT_OPC_LO         12
`define CISBT_LOAD_BIT       11
`define CISBT_REG_HI         10
`define CISBT_REG_LO         8
`define CISBT_EXTRA_BIT      8
`define CISBT_SIGN_BIT       7
`define CISBT_OPC_SPREL      4'h9
`define CISBT_OPC_LDADDR     4'hA
`define CISBT_OPC_MISC       4'hB
`define CISBT_OPC_MULTI      4'hC
`define CISBT_SUB_SPADJ      4'h0
`define CISBT_SUB_PUSHPOP    2'h2

`define CISBT_CYC_ONE        4'h1
`define CISBT_CYC_LOAD_ADD   4'h2
`define CISBT_CYC_STORE_ADD  4'h1
`define CISBT_CYC_PC_ADD     4'h2

`endif

// ===== hdl/cisbt_pkg.sv
// types shared by the stack/block transfer unit
package cisbt_pkg;

    typedef enum logic [5:0] {
        FMT_NONE    = 6'b00_0001,
        FMT_SPREL   = 6'b00_0010,
        FMT_LDADDR  = 6'b00_0100,
        FMT_SPADJ   = 6'b00_1000,
        FMT_PUSHPOP = 6'b01_0000,
        FMT_MULTI   = 6'b10_0000
    } cisbt_fmt_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_EXEC   = 4'b0010,
        ST_XFER   = 4'b0100,
        ST_FINISH = 4'b1000
    } cisbt_state_t;

endpackage

// ===== hdl/cisbt_decode.sv
// field decoder for the five compact stack and block transfer formats
`timescale 1ns/100ps
`include "cisbt_cfg.svh"

module cisbt_decode
    import cisbt_pkg::*;
(
    // instruction word
    input  wire logic [15:0] instr,
    // decoded fields
    output cisbt_fmt_t       fmt,
    output logic             load_sel,
    output logic [2:0]       reg_sel,
    output logic [7:0]       word_offset_field,
    output logic             neg_sel,
    output logic [6:0]       signed_word_offset_field,
    output logic             extra_sel,
    output logic [7:0]       reg_list
);

    logic [3:0] opc;

    assign opc = instr[`CISBT_OPC_HI:`CISBT_OPC_LO];

    always_comb begin
        fmt = FMT_NONE;
        if (opc == `CISBT_OPC_SPREL) begin
            fmt = FMT_SPREL;
        end else if (opc == `CISBT_OPC_LDADDR) begin
            fmt = FMT_LDADDR;
        end else if (opc == `CISBT_OPC_MISC && instr[11:8] == `CISBT_SUB_SPADJ) begin
            fmt = FMT_SPADJ;
        end else if (opc == `CISBT_OPC_MISC && instr[10:9] == `CISBT_SUB_PUSHPOP) begin
            fmt = FMT_PUSHPOP;
        end else if (opc == `CISBT_OPC_MULTI) begin
            fmt = FMT_MULTI;
        end
    end

    assign load_sel                 = instr[`CISBT_LOAD_BIT];
    assign reg_sel                  = instr[`CISBT_REG_HI:`CISBT_REG_LO];
    assign word_offset_field        = instr[7:0];
    assign neg_sel                  = instr[`CISBT_SIGN_BIT];
    assign signed_word_offset_field = instr[6:0];
    assign extra_sel                = instr[`CISBT_EXTRA_BIT];
    assign reg_list                 = instr[7:0];

endmodule // cisbt_decode

// ===== hdl/cisbt_top.sv
// execute unit for compact stack-relative, load-address, stack-adjust, push/pop, block transfer
`timescale 1ns/100ps
`include "cisbt_cfg.svh"

// Notes on behaviour
// - store with load bit 0 goes to stack pointer plus zero-extended word offset.
// - load bit 1 loads the word at stack pointer plus unsigned offset.
// - 8-bit word offset is shifted left two, giving a 10-bit byte offset.
// - load-address with source bit 0 writes pc base plus immediate.
// - load-address with source bit 1 writes stack pointer plus immediate.
// - load-address immediate is the 8-bit word field shifted left two.
// - pc base is instruction address plus 4 with bit 1 cleared.
// - load-address leaves the status flags untouched.
// - stack adjust adds a sign plus 7-bit word magnitude scaled by four.
// - sign bit 1 subtracts the magnitude, sign bit 0 adds it.
// - stack adjust leaves the status flags untouched.
// - push/pop move low registers by mask, plus link on push or pc on pop.
// - full descending stack, push decrements first, pop increments after, sp written back.
// - push stores masked registers below the stack pointer with writeback.
// - push with extra bit stores the link register even with an empty mask.
// - pop with extra bit loads masked registers then pc, then updates sp.
// - block store writes masked low registers from the base, then writes base back.
// - block load fills masked low registers from the base, then writes base back unless the base is in the mask.
// - address advances one word per transferred register.
// - each instruction takes the cycle count of its full-width equivalent.
module cisbt_top
    import cisbt_pkg::*;
(
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // memory access path
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    // status
    output logic             busy
);

    cisbt_state_t state_q;
    cisbt_fmt_t   fmt;
    logic [15:0]  instr_q;
    logic [31:0]  low_q [8];
    logic [31:0]  sp_q, lr_q, pc_q, psw_q;
    logic         pc_loaded_q, illegal_q;
    logic [3:0]   cyc_q, tgt_q, last_cyc_q;
    logic [8:0]   mask_q, mask_d, next_mask;
    logic [3:0]   cur_idx, n_slots;
    logic         wb_en_q, wb_sp_q;
    logic [2:0]   wb_reg_q;
    logic [31:0]  wb_val_q, wb_val_d, start_addr, pc_base, imm10, mag9, bytes_n;
    logic [31:0]  rdata_d;
    logic         load_sel, neg_sel, extra_sel, xfer_d;
    logic [2:0]   reg_sel;
    logic [7:0]   word_offset_field, reg_list;
    logic [6:0]   signed_word_offset_field;
    logic [3:0]   tgt_d;
    logic         apb_setup, apb_wr, start, fin_now, fin_xfer, fin_wait, done;

    function automatic logic [3:0] lowest(input logic [8:0] m);
        lowest = 4'h0;
        for (int i = 8; i >= 0; i--) begin
            if (m[i]) begin
                lowest = 4'(i);
            end
        end
    endfunction

    function automatic logic [3:0] count9(input logic [8:0] m);
        count9 = 4'h0;
        for (int i = 0; i < 9; i++) begin
            count9 = count9 + {3'h0, m[i]};
        end
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a[7:5] == `CISBT_LOW_TOP || a <= `CISBT_OFF_CYCLES);
    endfunction

    cisbt_decode u_decode (
        .instr                    (instr_q),
        .fmt                      (fmt),
        .load_sel                 (load_sel),
        .reg_sel                  (reg_sel),
        .word_offset_field        (word_offset_field),
        .neg_sel                  (neg_sel),
        .signed_word_offset_field (signed_word_offset_field),
        .extra_sel                (extra_sel),
        .reg_list                 (reg_list)
    );

    // operand and address arithmetic
    assign pc_base = (pc_q + `CISBT_PC_AHEAD) & ~`CISBT_PC_BIT1;
    assign imm10   = {22'h0, word_offset_field, 2'b00};
    assign mag9    = {23'h0, signed_word_offset_field, 2'b00};
    assign n_slots = count9(mask_d);
    assign bytes_n = {26'h0, n_slots, 2'b00};

    always_comb begin
        mask_d     = 9'h000;
        start_addr = sp_q;
        wb_val_d   = sp_q;
        if (fmt == FMT_SPREL) begin
            mask_d     = 9'h001 << reg_sel;
            start_addr = sp_q + imm10;
        end else if (fmt == FMT_PUSHPOP && !load_sel) begin
            mask_d     = {extra_sel, reg_list};
            start_addr = sp_q - bytes_n;
            wb_val_d   = sp_q - bytes_n;
        end else if (fmt == FMT_PUSHPOP) begin
            mask_d     = {extra_sel, reg_list};
            wb_val_d   = sp_q + bytes_n;
        end else if (fmt == FMT_MULTI) begin
            mask_d     = {1'b0, reg_list};
            start_addr = low_q[reg_sel];
            wb_val_d   = low_q[reg_sel] + bytes_n;
        end
    end

    // full-width equivalent timing: loads n+2 (+2 pipeline refill on pc), stores n+1
    assign tgt_d = load_sel ? n_slots + `CISBT_CYC_LOAD_ADD + (mask_d[8] ? `CISBT_CYC_PC_ADD : 4'h0)
                            : n_slots + `CISBT_CYC_STORE_ADD;

    assign cur_idx   = lowest(mask_q);
    assign next_mask = mask_q & ~(9'h001 << cur_idx);
    assign xfer_d    = (fmt == FMT_SPREL || fmt == FMT_PUSHPOP || fmt == FMT_MULTI)
                       && mask_d != 9'h000;
    assign fin_now   = state_q == ST_EXEC && !xfer_d;
    assign fin_xfer  = state_q == ST_XFER && mem_ack && next_mask == 9'h000 && cyc_q >= tgt_q;
    assign fin_wait  = state_q == ST_FINISH && cyc_q >= tgt_q;
    assign done      = fin_now || fin_xfer || fin_wait;

    // apb slave: no wait states, pready rises on the edge that ends setup
    assign apb_setup = psel && !penable && !pready;
    assign apb_wr    = psel && penable && pready && pwrite && !pslverr;
    assign start     = apb_wr && paddr == `CISBT_OFF_INSTR;

    always_comb begin
        rdata_d = `CISBT_RST_WORD;
        if (paddr[7:5] == `CISBT_LOW_TOP) begin
            rdata_d = low_q[paddr[4:2]];
        end else if (paddr == `CISBT_OFF_INSTR) begin
            rdata_d = {16'h0, instr_q};
        end else if (paddr == `CISBT_OFF_STATUS) begin
            rdata_d = {29'h0, pc_loaded_q, illegal_q, busy};
        end else if (paddr == `CISBT_OFF_PC) begin
            rdata_d = pc_q;
        end else if (paddr == `CISBT_OFF_PSW) begin
            rdata_d = psw_q;
        end else if (paddr == `CISBT_OFF_SP) begin
            rdata_d = sp_q;
        end else if (paddr == `CISBT_OFF_LR) begin
            rdata_d = lr_q;
        end else if (paddr == `CISBT_OFF_CYCLES) begin
            rdata_d = {28'h0, last_cyc_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `CISBT_RST_WORD;
        end else if (clk_en) begin
            pready <= apb_setup;
            if (apb_setup) begin
                // writes while an instruction runs would tear its operands
                pslverr <= !addr_ok(paddr) || (pwrite && busy);
                prdata  <= pwrite ? `CISBT_RST_WORD : rdata_d;
            end
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_IDLE;
            busy       <= 1'b0;
            instr_q    <= 16'h0000;
            cyc_q      <= 4'h0;
            tgt_q      <= 4'h0;
            last_cyc_q <= 4'h0;
            illegal_q  <= 1'b0;
            wb_en_q    <= 1'b0;
            wb_sp_q    <= 1'b0;
            wb_reg_q   <= 3'h0;
            wb_val_q   <= `CISBT_RST_WORD;
        end else if (clk_en) begin
            if (state_q != ST_IDLE) begin
                cyc_q <= cyc_q + 4'h1;
            end
            if (done) begin
                last_cyc_q <= cyc_q;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        instr_q <= pwdata[15:0];
                        busy    <= 1'b1;
                        cyc_q   <= `CISBT_CYC_ONE;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    illegal_q <= fmt == FMT_NONE;
                    tgt_q     <= tgt_d;
                    wb_sp_q   <= fmt == FMT_PUSHPOP;
                    wb_reg_q  <= reg_sel;
                    wb_val_q  <= wb_val_d;
                    // a block load that names its own base keeps the loaded value
                    wb_en_q   <= fmt == FMT_PUSHPOP || (fmt == FMT_MULTI
                                 && !(load_sel && reg_list[reg_sel]));
                    if (fin_now) begin
                        busy    <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (fin_xfer) begin
                        busy    <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (mem_ack && next_mask == 9'h000) begin
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    if (fin_wait) begin
                        busy    <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // memory access path, held until acknowledged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= `CISBT_RST_WORD;
            mem_wdata <= `CISBT_RST_WORD;
            mask_q    <= 9'h000;
        end else if (clk_en) begin
            if (state_q == ST_EXEC && xfer_d) begin
                mem_req   <= 1'b1;
                mem_we    <= !load_sel;
                mem_addr  <= start_addr;
                mask_q    <= mask_d;
                mem_wdata <= mask_d[lowest(mask_d)] && lowest(mask_d) == 4'h8 ? lr_q
                             : low_q[3'(lowest(mask_d))];
            end else if (state_q == ST_XFER && mem_ack) begin
                mask_q <= next_mask;
                if (next_mask != 9'h000) begin
                    mem_addr  <= mem_addr + 32'h0000_0004;
                    mem_wdata <= lowest(next_mask) == 4'h8 ? lr_q : low_q[3'(lowest(next_mask))];
                end else begin
                    mem_req <= 1'b0;
                end
            end
        end
    end

    // architectural registers; flags change only from software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                low_q[i] <= `CISBT_RST_WORD;
            end
            sp_q        <= `CISBT_RST_WORD;
            lr_q        <= `CISBT_RST_WORD;
            pc_q        <= `CISBT_RST_WORD;
            psw_q       <= `CISBT_RST_WORD;
            pc_loaded_q <= 1'b0;
        end else if (clk_en) begin
            if (apb_wr && paddr[7:5] == `CISBT_LOW_TOP) begin
                low_q[paddr[4:2]] <= pwdata;
            end else if (apb_wr && paddr == `CISBT_OFF_PC) begin
                pc_q <= pwdata;
            end else if (apb_wr && paddr == `CISBT_OFF_PSW) begin
                psw_q <= pwdata;
            end else if (apb_wr && paddr == `CISBT_OFF_SP) begin
                sp_q <= pwdata;
            end else if (apb_wr && paddr == `CISBT_OFF_LR) begin
                lr_q <= pwdata;
            end
            if (start) begin
                pc_loaded_q <= 1'b0;
            end
            if (state_q == ST_EXEC && fmt == FMT_LDADDR) begin
                low_q[reg_sel] <= (load_sel ? sp_q : pc_base) + imm10;
            end
            if (state_q == ST_EXEC && fmt == FMT_SPADJ) begin
                sp_q <= neg_sel ? sp_q - mag9 : sp_q + mag9;
            end
            if (state_q == ST_XFER && mem_ack && !mem_we) begin
                if (cur_idx == 4'h8) begin
                    pc_q        <= mem_rdata & ~`CISBT_PC_BIT0;
                    pc_loaded_q <= 1'b1;
                end else begin
                    low_q[cur_idx[2:0]] <= mem_rdata;
                end
            end
            if (done && wb_en_q && state_q != ST_EXEC) begin
                if (wb_sp_q) begin
                    sp_q <= wb_val_q;
                end else begin
                    low_q[wb_reg_q] <= wb_val_q;
                end
            end
            if (done && !pc_loaded_q && !(state_q == ST_XFER && cur_idx == 4'h8 && !mem_we)) begin
                pc_q <= pc_q + `CISBT_PC_STEP;
            end
        end
    end

    sequence s_str_start;
        clk_en && state_q == ST_EXEC && fmt == FMT_SPREL && !load_sel;
    endsequence

    sequence s_first_ack;
        ##1 (clk_en && mem_ack);
    endsequence

    a_sprel_addr: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ST_EXEC && fmt == FMT_SPREL |=>
            mem_addr == $past(sp_q) + {22'h0, $past(word_offset_field), 2'b00})
        else $error("stack-relative address wrong");

    a_sprel_dir: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ST_EXEC && fmt == FMT_SPREL |=> mem_req && mem_we == !$past(load_sel))
        else $error("stack-relative direction wrong");

    a_ldaddr_val: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ST_EXEC && fmt == FMT_LDADDR |=>
            low_q[$past(reg_sel)] == ($past(load_sel) ? $past(sp_q)
            : (($past(pc_q) + 32'h0000_0004) & 32'hFFFF_FFFD)) + $past(imm10))
        else $error("load-address result wrong");

    a_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
        busy |=> $stable(psw_q))
        else $error("flags changed during instruction");

    a_spadj_val: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ST_EXEC && fmt == FMT_SPADJ |=>
            sp_q == ($past(neg_sel) ? $past(sp_q) - $past(mag9) : $past(sp_q) + $past(mag9)))
        else $error("stack adjust wrong");

    a_push_base: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ST_EXEC && fmt == FMT_PUSHPOP && !load_sel && extra_sel |=>
            mask_q[8] && mem_addr == $past(sp_q) - {26'h0, $past(n_slots), 2'b00})
        else $error("push start wrong");

    a_addr_step: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ST_XFER && mem_ack && next_mask != 9'h000 |=>
            mem_addr == $past(mem_addr) + 32'h0000_0004 && cur_idx > $past(cur_idx))
        else $error("transfer step wrong");

    a_pop_pc: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ST_XFER && mem_ack && !mem_we && cur_idx == 4'h8 |=>
            pc_q == ($past(mem_rdata) & 32'hFFFF_FFFE) && next_mask == 9'h000)
        else $error("pop pc wrong");

    a_str_time: assert property (@(posedge pclk) disable iff (!presetn)
        s_str_start ##0 s_first_ack |=> !busy)
        else $error("single store cycle count wrong");

    // a frozen done edge writes nothing, so clk_en qualifies the trigger
    a_block_wb: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && done && wb_en_q && !wb_sp_q && state_q != ST_EXEC |=>
            low_q[$past(wb_reg_q)] == $past(wb_val_q))
        else $error("base writeback wrong");

endmodule // cisbt_top

// ===== tb/cisbt_tb.sv
// self-checking bench for the compact stack and block transfer unit
`timescale 1ns/100ps
module testbench;
    import cisbt_pkg::*;
    localparam logic [31:0] RD_MIX = 32'h5a5a_0000;
    logic        pclk = 0, presetn = 0, clk_en = 1;
    logic        psel = 0, penable = 0, pwrite = 0, mem_ack = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic        pready, pslverr, mem_req, mem_we, busy, err;
    int          n_mismatch = 0, checks = 0, stall = 0;
    int          r[8], sp, lr, pc, psw, w, d, m, b, a, n, f;
    int          q[$];
    always #50 pclk = ~pclk;
    // load data is a known mix of its address so the model can predict it
    assign mem_rdata = mem_addr ^ RD_MIX;
    cisbt_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(t < 50, 1, "apb hang");
    endtask
    task automatic ex(input int ad, input int we, input int dt);
        q.push_back(ad);
        q.push_back(we);
        q.push_back(dt);
    endtask
    task automatic state;
        apb(0, 8'h10, 0);
        chk(rd, sp, "sp");
        apb(0, 8'h08, 0);
        chk(rd, pc, "pc");
        apb(0, 8'h0c, 0);
        chk(rd, psw, "flags");
        apb(0, 8'h14, 0);
        chk(rd, lr, "lr");
        for (int k = 0; k < 8; k++) begin
            apb(0, 8'h20 + 8'(4 * k), 0);
            chk(rd, r[k], "low reg");
        end
    endtask
    task automatic run(input int i, input int cyc);
        int t;
        apb(1, 8'h00, 32'(i));
        t = 0;
        @(posedge pclk);
        while (busy !== 1'b0 && t < 300) begin
            @(posedge pclk);
            t++;
        end
        chk(t < 300, 1, "busy stuck");
        chk(q.size(), 0, "memory words missing");
        // stalls stretch the count, so it is judged on zero-wait passes only
        if (stall == 0) begin
            apb(0, 8'h18, 0);
            chk(rd, cyc, "cycle count");
        end
        state();
        $display("instr %h done", i[15:0]);
    endtask
    task automatic setup;
        sp = $urandom & 32'hffff_fffc;
        lr = $urandom;
        pc = 32'h0000_0100 + 2 * ($urandom % 64);
        psw = $urandom & 32'hf000_0000;
        apb(1, 8'h10, sp);
        apb(1, 8'h14, lr);
        apb(1, 8'h08, pc);
        apb(1, 8'h0c, psw);
        for (int k = 0; k < 8; k++) begin
            r[k] = $urandom & 32'hffff_fffc;
            apb(1, 8'h20 + 8'(4 * k), r[k]);
        end
    endtask
    always @(posedge pclk) begin
        mem_ack <= stall ? 1'($urandom % 2) : 1'b1;
        // freeze only mid-instruction, bus transfers included
        clk_en <= (stall && busy === 1'b1) ? (($urandom % 4) != 0) : 1'b1;
        if (mem_req === 1'b1 && mem_ack === 1'b1 && clk_en === 1'b1) begin
            if (q.size() < 3) chk(0, 1, "extra memory word");
            else begin
                chk(mem_addr, q.pop_front(), "mem address");
                f = q.pop_front();
                chk(32'(mem_we), f, "mem direction");
                f = q.pop_front();
                if (mem_we) chk(mem_wdata, f, "mem data");
            end
        end
    end
    initial begin
        #2_000_000;
        n_mismatch++;
        conclude();
    end
    initial begin
        void'($urandom(32'h2cb3));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h10, 0);
        chk(rd, 32'h0000_0000, "sp after reset");
        apb(0, 8'h40, 0);
        chk(err, 1, "unmapped read");
        for (int p = 0; p < 2; p++) begin
            stall = p;
            setup();
            w = p ? $urandom % 256 : 255;
            d = $urandom % 8;
            ex(sp + 4 * w, 1, r[d]);
            pc += 2;
            run(32'h9000 | d << 8 | w, 2);
            ex(sp + 4 * w, 0, 0);
            r[d] = (sp + 4 * w) ^ RD_MIX;
            pc += 2;
            run(32'h9800 | d << 8 | w, 3);
            r[d] = ((pc + 4) & ~2) + 4 * w;
            pc += 2;
            run(32'ha000 | d << 8 | w, 1);
            r[d] = sp + 4 * w;
            pc += 2;
            run(32'ha800 | d << 8 | w, 1);
            for (int s = 0; s < 2; s++) begin
                w = p ? $urandom % 128 : 127;
                sp += s ? -4 * w : 4 * w;
                pc += 2;
                run(32'hb000 | s << 7 | w, 1);
            end
            m = p ? $urandom % 256 : 0;
            n = $countones(8'(m));
            a = sp - 4 * (n + 1);
            sp = a;
            for (int k = 0; k < 8; k++) if (m[k]) begin ex(a, 1, r[k]); a += 4; end
            ex(a, 1, lr);
            pc += 2;
            run(32'hb500 | m, n + 2);
            m = $urandom % 256;
            n = $countones(8'(m));
            a = sp;
            for (int k = 0; k < 8; k++) if (m[k]) begin ex(a, 0, 0); r[k] = a ^ RD_MIX; a += 4; end
            ex(a, 0, 0);
            pc = (a ^ RD_MIX) & ~1;
            sp = a + 4;
            run(32'hbd00 | m, n + 5);
            for (int l = 0; l < 2; l++) begin
                b = $urandom % 8;
                m = $urandom % 256;
                n = $countones(8'(m));
                a = r[b];
                for (int k = 0; k < 8; k++) if (m[k]) begin
                    ex(a, 1 - l, r[k]);
                    if (l) r[k] = a ^ RD_MIX;
                    a += 4;
                end
                if (m != 0 && !(l && m[b])) r[b] = a;
                pc += 2;
                run(32'hc000 | l << 11 | b << 8 | m, m ? n + 1 + l : 1);
            end
        end
        conclude();
    end
endmodule // testbench
